// File: rtl/flaa_map.vh
// Purpose: Constants for the field level alarm annunciator core
// Assumes: 125 MHz reference clock, APB register access
// Notes:   Offsets are byte addresses, one 32-bit word each
`ifndef FLAA_MAP_VH
`define FLAA_MAP_VH
// ====================================================
// Register offsets
`define FLAA_OFF_CTRL      12'h000
`define FLAA_OFF_ALM1      12'h004
`define FLAA_OFF_ALM2      12'h008
`define FLAA_OFF_STATUS    12'h00C
`define FLAA_OFF_LEVEL     12'h010
`define FLAA_OFF_LOG       12'h014
// ====================================================
// Control fields, reset values and alarm threshold limits
`define FLAA_IND_LSB       0
`define FLAA_RATE_LSB      2
`define FLAA_BL_LSB        5
`define FLAA_IND_RST       2'h0
`define FLAA_RATE_RST      3'h1
`define FLAA_BL_RST        3'h1
`define FLAA_ALM1_RST      8'h32
`define FLAA_ALM2_RST      8'hC8
`define FLAA_ALM1_MIN      8'h05
`define FLAA_ALM1_MAX      8'h64
`define FLAA_ALM2_MIN      8'h14
`define FLAA_ALM2_MAX      8'hC8
// ====================================================
// Encodings
`define FLAA_IND_BOTH      2'h0
`define FLAA_IND_TONE      2'h1
`define FLAA_IND_VIB       2'h2
`define FLAA_RATE_4HZ      3'h0
`define FLAA_RATE_1HZ      3'h1
`define FLAA_RATE_5S       3'h2
`define FLAA_RATE_20S      3'h3
`define FLAA_RATE_60S      3'h4
`define FLAA_BL_OFF        3'h0
`define FLAA_BL_10S        3'h1
`define FLAA_BL_30S        3'h2
`define FLAA_BL_60S        3'h3
`define FLAA_BL_ON         3'h4
// ====================================================
// Timing and battery thresholds
`define FLAA_SAMPLE_MS     32
`define FLAA_CLK_KHZ       125000
`define FLAA_SAMP_PER_LOG  3'h7
`define FLAA_SAMP_PER_SEC  5'h1F
`define FLAA_HB_SEC        4'h9
`define FLAA_TONE_LAST     3'h4
`define FLAA_CAL_WAIT      3'h4
`define FLAA_BATT_RED      7'h14
`define FLAA_BATT_WARN     7'h0A
`endif

// File: rtl/flaa_core.v
// Purpose: Field level monitor core: sampling, averaging, alarms, indicators
// Assumes: Sensor pins and keys are asynchronous; calibration memory answers
//          a held address with stable data within a few cycles
// Notes:   Levels are in percent of the limit; one second is 32 sample ticks
// ====================================================
// Summary of operation
// - Sample the sensor every 32 ms, timed from the system clock.
// - Each fastest-rate log record averages eight consecutive samples.
// - Display level refreshes each second as mean of four log records.
// - Logging rate is configurable, fastest four records per second.
// - Alarm 1 alternates tone and vibrator at about one second period.
// - Alarm 1 lights red and amber LEDs on one side only.
// - Alarm 2 steps through five tones, vibrator at twice alarm 1 rate.
// - Alarm 2 flashes red and amber LEDs on both sides alternately.
// - With only one alarm configured, use the alarm 2 pattern.
// - Default backlight switches off 10 seconds after last activation.
// - Any brief key press turns backlight on and restarts timeout.
// - Heartbeat LED flashes briefly once every 10 seconds.
// - Battery indicator always shown, red background below 20 percent.
// - Below 10 percent charge warn by tone and LEDs, no vibrator or backlight.
// - Enter alarm 1 when level reaches first threshold, default 50 percent.
// - Scale each of three detectors by its own coefficient from sensor memory.
// - Threshold 1 is 5 to 100 percent or off; threshold 2 is 20 to 200.
// - Indication selectable tone+vibrator, tone only, vibrator only; default both.
// - Logging interval 4/s, 1/s, 5 s, 20 s or 60 s; default 1/s.
//
// The address map and the APB interface to the registers are this design's own decisions.
`include "flaa_map.vh"
`timescale 1ns/10ps
`default_nettype none
module flaa_core #(
	parameter SAMPLE_CYC = `FLAA_SAMPLE_MS * `FLAA_CLK_KHZ
) (
	input  wire        ref_clk,
	input  wire        arst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [11:0] det0,
	input  wire [11:0] det1,
	input  wire [11:0] det2,
	output reg  [1:0]  cal_addr,
	input  wire [15:0] cal_rdata,
	input  wire [2:0]  key_n,
	input  wire [6:0]  batt_pct,
	output reg         tone_en,
	output reg  [2:0]  tone_sel,
	output reg         vib_en,
	output reg         led_red_left,
	output reg         led_amber_left,
	output reg         led_red_right,
	output reg         led_amber_right,
	output reg         backlight,
	output reg         heartbeat_led,
	output reg         batt_red_bg,
	output reg         log_valid,
	output reg  [15:0] log_level
);
// ====================================================
// Functions
function [15:0] scale;
	input [11:0] det;
	input [15:0] coef;
	reg   [27:0] prod;
	begin
		prod  = det * coef;
		// Saturate instead of wrapping when a large coefficient overflows 16 bits
		scale = (prod[27:24] != 4'h0) ? 16'hFFFF : prod[23:8];
	end
endfunction

function [7:0] clamp;
	input [7:0] v;
	input [7:0] lo;
	input [7:0] hi;
	begin
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	end
endfunction

// ====================================================
// Input synchronisers
reg [35:0] det_s1_q, det_s2_q;
reg [15:0] cal_s1_q, cal_s2_q;
reg [2:0]  key_s1_q, key_s2_q, key_prev_q;
reg [6:0]  bat_s1_q, bat_s2_q;
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		det_s1_q   <= 36'h0_0000_0000;
		det_s2_q   <= 36'h0_0000_0000;
		cal_s1_q   <= 16'h0000;
		cal_s2_q   <= 16'h0000;
		key_s1_q   <= 3'h7;
		key_s2_q   <= 3'h7;
		key_prev_q <= 3'h7;
		bat_s1_q   <= 7'h64;
		bat_s2_q   <= 7'h64;
	end else begin
		det_s1_q   <= {det2, det1, det0};
		det_s2_q   <= det_s1_q;
		cal_s1_q   <= cal_rdata;
		cal_s2_q   <= cal_s1_q;
		key_s1_q   <= key_n;
		key_s2_q   <= key_s1_q;
		key_prev_q <= key_s2_q;
		bat_s1_q   <= batt_pct;
		bat_s2_q   <= bat_s1_q;
	end
end
wire key_press = |(key_prev_q & ~key_s2_q);

// ====================================================
// Calibration read from sensor memory
localparam CAL_ADDR = 2'd0;
localparam CAL_WAIT = 2'd1;
localparam CAL_DONE = 2'd2;
reg [1:0]  cal_st_q;
reg [2:0]  cal_wcnt_q;
reg [15:0] coef_q [0:2];
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		cal_st_q   <= CAL_ADDR;
		cal_wcnt_q <= 3'h0;
		cal_addr   <= 2'h0;
		coef_q[0]  <= 16'h0000;
		coef_q[1]  <= 16'h0000;
		coef_q[2]  <= 16'h0000;
	end else begin
		case (cal_st_q)
		CAL_ADDR: begin
			cal_wcnt_q <= 3'h0;
			cal_st_q   <= CAL_WAIT;
		end
		CAL_WAIT: begin
			cal_wcnt_q <= cal_wcnt_q + 3'h1;
			if (cal_wcnt_q == `FLAA_CAL_WAIT) begin
				coef_q[cal_addr] <= cal_s2_q;
				if (cal_addr == 2'h2) begin
					cal_st_q <= CAL_DONE;
				end else begin
					cal_addr <= cal_addr + 2'h1;
					cal_st_q <= CAL_ADDR;
				end
			end
		end
		CAL_DONE: cal_st_q <= CAL_DONE;
		default:  cal_st_q <= CAL_ADDR;
		endcase
	end
end
wire cal_done = (cal_st_q == CAL_DONE);

// ====================================================
// Registers and APB slave
reg [1:0] ind_q;
reg [2:0] rate_q, bl_q;
reg [7:0] alm1_q, alm2_q;
reg [1:0] alarm_q;
reg [15:0] disp_q;
reg [15:0] last_log_q;
wire low20 = (bat_s2_q < `FLAA_BATT_RED);
wire low10 = (bat_s2_q < `FLAA_BATT_WARN);
wire hit   = (paddr == `FLAA_OFF_CTRL) || (paddr == `FLAA_OFF_ALM1) ||
             (paddr == `FLAA_OFF_ALM2) || (paddr == `FLAA_OFF_STATUS) ||
             (paddr == `FLAA_OFF_LEVEL) || (paddr == `FLAA_OFF_LOG);
wire wr_en = psel & penable & pready & pwrite & ~pslverr;
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= 32'h0000_0000;
		ind_q   <= `FLAA_IND_RST;
		rate_q  <= `FLAA_RATE_RST;
		bl_q    <= `FLAA_BL_RST;
		alm1_q  <= `FLAA_ALM1_RST;
		alm2_q  <= `FLAA_ALM2_RST;
	end else begin
		pready  <= psel & ~penable;
		pslverr <= psel & ~penable & ~hit;
		if (psel & ~penable & ~pwrite) begin
			case (paddr)
			`FLAA_OFF_CTRL:   prdata <= {24'h00_0000, bl_q, rate_q, ind_q};
			`FLAA_OFF_ALM1:   prdata <= {24'h00_0000, alm1_q};
			`FLAA_OFF_ALM2:   prdata <= {24'h00_0000, alm2_q};
			`FLAA_OFF_STATUS: prdata <= {27'h000_0000, cal_done, low10, low20, alarm_q};
			`FLAA_OFF_LEVEL:  prdata <= {16'h0000, disp_q};
			`FLAA_OFF_LOG:    prdata <= {16'h0000, last_log_q};
			default:          prdata <= 32'h0000_0000;
			endcase
		end
		if (wr_en) begin
			case (paddr)
			`FLAA_OFF_CTRL: begin
				ind_q  <= (pwdata[1:0] == 2'h3) ? `FLAA_IND_BOTH : pwdata[1:0];
				rate_q <= (pwdata[4:2] > `FLAA_RATE_60S) ? `FLAA_RATE_60S : pwdata[4:2];
				bl_q   <= (pwdata[7:5] > `FLAA_BL_ON) ? `FLAA_BL_ON : pwdata[7:5];
			end
			`FLAA_OFF_ALM1: alm1_q <= (pwdata[7:0] == 8'h00) ? 8'h00 :
			                clamp(pwdata[7:0], `FLAA_ALM1_MIN, `FLAA_ALM1_MAX);
			`FLAA_OFF_ALM2: alm2_q <= clamp(pwdata[7:0], `FLAA_ALM2_MIN, `FLAA_ALM2_MAX);
			default: ;
			endcase
		end
	end
end

// ====================================================
// Sample timebase and averaging
reg [31:0] div_q;
reg [4:0]  samp_q;
reg [18:0] acc8_q;
reg [17:0] acc4_q;
reg [5:0]  lsec_q;
reg [3:0]  hb_q;
reg        samp_tick_q;
wire [17:0] sum3 = {2'b00, scale(det_s2_q[11:0],  coef_q[0])} +
                   {2'b00, scale(det_s2_q[23:12], coef_q[1])} +
                   {2'b00, scale(det_s2_q[35:24], coef_q[2])};
wire [15:0] samp_lvl = (sum3[17:16] != 2'b00) ? 16'hFFFF : sum3[15:0];
wire [18:0] acc8_d   = acc8_q + {3'h0, samp_lvl};
wire [15:0] fast_log = acc8_d[18:3];
wire        log_tick = samp_tick_q & (samp_q[2:0] == `FLAA_SAMP_PER_LOG);
wire        sec_tick = samp_tick_q & (samp_q == `FLAA_SAMP_PER_SEC);
wire [17:0] acc4_d   = acc4_q + {2'b00, fast_log};
reg  [5:0]  lsec_lim;
always @* begin
	case (rate_q)
	`FLAA_RATE_5S:  lsec_lim = 6'd4;
	`FLAA_RATE_20S: lsec_lim = 6'd19;
	`FLAA_RATE_60S: lsec_lim = 6'd59;
	default:        lsec_lim = 6'd0;
	endcase
end
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		div_q       <= 32'h0000_0000;
		samp_tick_q <= 1'b0;
		samp_q      <= 5'h00;
		acc8_q      <= 19'h0_0000;
		acc4_q      <= 18'h0_0000;
		disp_q      <= 16'h0000;
		last_log_q  <= 16'h0000;
		lsec_q      <= 6'h00;
		// Start past zero so no stretched flash follows the calibration read
		hb_q        <= 4'h1;
		log_valid   <= 1'b0;
		log_level   <= 16'h0000;
	end else begin
		samp_tick_q <= 1'b0;
		log_valid   <= 1'b0;
		if (cal_done) begin
			if (div_q == SAMPLE_CYC - 1) begin
				div_q       <= 32'h0000_0000;
				samp_tick_q <= 1'b1;
			end else begin
				div_q <= div_q + 32'h0000_0001;
			end
		end
		if (samp_tick_q) begin
			samp_q <= samp_q + 5'h01;
			acc8_q <= log_tick ? 19'h0_0000 : acc8_d;
		end
		if (log_tick) begin
			last_log_q <= fast_log;
			acc4_q     <= sec_tick ? 18'h0_0000 : acc4_d;
			if (rate_q == `FLAA_RATE_4HZ) begin
				log_valid <= 1'b1;
				log_level <= fast_log;
			end
		end
		if (sec_tick) begin
			disp_q <= acc4_d[17:2];
			hb_q   <= (hb_q == `FLAA_HB_SEC) ? 4'h0 : hb_q + 4'h1;
			if (rate_q != `FLAA_RATE_4HZ) begin
				if (lsec_q >= lsec_lim) begin
					lsec_q    <= 6'h00;
					log_valid <= 1'b1;
					log_level <= acc4_d[17:2];
				end else begin
					lsec_q <= lsec_q + 6'h01;
				end
			end
		end
	end
end

// ====================================================
// Alarm state, judged on every fast log so it reacts in 256 ms
localparam ALM_NONE = 2'd0;
localparam ALM_ONE  = 2'd1;
localparam ALM_TWO  = 2'd2;
wire over1 = (alm1_q != 8'h00) && (last_log_q >= {8'h00, alm1_q});
wire over2 = (last_log_q >= {8'h00, alm2_q});
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		alarm_q <= ALM_NONE;
	end else begin
		if (over2) begin
			alarm_q <= ALM_TWO;
		end else if (over1) begin
			alarm_q <= ALM_ONE;
		end else begin
			alarm_q <= ALM_NONE;
		end
	end
end

// ====================================================
// Indicators
reg [2:0] tone_idx_q;
reg [5:0] bl_cnt_q;
reg       bl_on_q;
reg [5:0] bl_lim;
always @* begin
	case (bl_q)
	`FLAA_BL_30S: bl_lim = 6'd30;
	`FLAA_BL_60S: bl_lim = 6'd60;
	default:      bl_lim = 6'd10;
	endcase
end
wire allow_tone = (ind_q != `FLAA_IND_VIB);
wire allow_vib  = (ind_q != `FLAA_IND_TONE);
wire ph1        = samp_q[4];
wire ph2        = samp_q[3];
always @(posedge ref_clk or negedge arst_n) begin
	if (!arst_n) begin
		tone_idx_q      <= 3'h0;
		bl_cnt_q        <= 6'h00;
		bl_on_q         <= 1'b0;
		tone_en         <= 1'b0;
		tone_sel        <= 3'h0;
		vib_en          <= 1'b0;
		led_red_left    <= 1'b0;
		led_amber_left  <= 1'b0;
		led_red_right   <= 1'b0;
		led_amber_right <= 1'b0;
		backlight       <= 1'b0;
		heartbeat_led   <= 1'b0;
		batt_red_bg     <= 1'b0;
	end else begin
		if (samp_tick_q && samp_q[2:0] == 3'h7) begin
			tone_idx_q <= (tone_idx_q == `FLAA_TONE_LAST) ? 3'h0 : tone_idx_q + 3'h1;
		end
		if (key_press) begin
			bl_on_q  <= 1'b1;
			bl_cnt_q <= 6'h00;
		end else if (sec_tick && bl_on_q) begin
			if (bl_cnt_q + 6'h01 >= bl_lim) begin
				bl_on_q <= 1'b0;
			end else begin
				bl_cnt_q <= bl_cnt_q + 6'h01;
			end
		end
		// Warning must not drain the battery further, so no backlight below 10 percent
		backlight     <= ~low10 & (bl_q == `FLAA_BL_ON ||
		                 (bl_q != `FLAA_BL_OFF && bl_on_q));
		heartbeat_led <= (hb_q == 4'h0) && (samp_q == 5'h00) && cal_done;
		batt_red_bg   <= low20;
		case (alarm_q)
		ALM_ONE: begin
			tone_en         <= allow_tone & ph1;
			vib_en          <= allow_vib & ~ph1;
			tone_sel        <= 3'h0;
			led_red_left    <= 1'b1;
			led_amber_left  <= 1'b1;
			led_red_right   <= 1'b0;
			led_amber_right <= 1'b0;
		end
		ALM_TWO: begin
			tone_en         <= allow_tone;
			tone_sel        <= tone_idx_q;
			vib_en          <= allow_vib & ph2;
			led_red_left    <= ph2;
			led_amber_left  <= ph2;
			led_red_right   <= ~ph2;
			led_amber_right <= ~ph2;
		end
		default: begin
			// Field alarms above win; the battery pattern only shows when quiet
			tone_en         <= low10 & ph1;
			tone_sel        <= 3'h0;
			vib_en          <= 1'b0;
			led_red_left    <= 1'b0;
			led_amber_left  <= low10 & ph1;
			led_red_right   <= 1'b0;
			led_amber_right <= low10 & ph1;
		end
		endcase
	end
end
endmodule
`default_nettype wire

// File: test/flaa_cal_mem.sv
// Purpose: Sensor calibration memory model for flaa_core
// Assumes: Address held steady while the core reads
// Notes:   Coefficients differ per detector so a stale or repeated read shows up in the level
`timescale 1ns/10ps
`default_nettype none
module flaa_cal_mem (
	input  wire logic [1:0]  cal_addr,
	output var  logic [15:0] cal_rdata
);
	// ====================================================
	// Coefficient store, 8.8 fixed point
	always_comb begin
		case (cal_addr)
			2'h0:    cal_rdata = 16'h0100;
			2'h1:    cal_rdata = 16'h0080;
			2'h2:    cal_rdata = 16'h0200;
			// Unused slot returns a pattern so a stray read cannot look valid
			default: cal_rdata = 16'hA5C3;
		endcase
	end
endmodule
`default_nettype wire

// File: test/flaa_core_chk.sv
// Purpose: Port assertions for flaa_core
// Assumes: Single clock domain, asynchronous active low reset
// Notes:   Bound to every flaa_core instance
`timescale 1ns/10ps
`default_nettype none
module flaa_core_chk #(
	parameter int SAMPLE_CYC = 8
) (
	input wire       ref_clk,
	input wire       arst_n,
	input wire       psel,
	input wire       penable,
	input wire       pready,
	input wire       pslverr,
	input wire [6:0] batt_pct,
	input wire       backlight,
	input wire       batt_red_bg,
	input wire       led_red_left,
	input wire       led_red_right,
	input wire [2:0] tone_sel,
	input wire       log_valid,
	input wire       heartbeat_led
);
	int hb_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// ====================================================
	// Heartbeat length counter
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) hb_q <= 0;
		else hb_q <= heartbeat_led ? hb_q + 1 : 0;
	end
	// ====================================================
	// Assertions
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_red_alternate: assert property (!(led_red_left && led_red_right))
		else $error("both red leds lit");
	chk_tone_range: assert property (tone_sel <= 3'h4)
		else $error("tone index out of range");
	chk_log_pulse: assert property (log_valid |=> !log_valid)
		else $error("log strobe too long");
	chk_low_batt: assert property ((batt_pct < 7'h0A) [*8] |-> !backlight)
		else $error("backlight on at low charge");
	chk_batt_red: assert property ((batt_pct < 7'h14) [*8] |-> batt_red_bg)
		else $error("battery background not red");
	chk_heart_short: assert property (hb_q <= SAMPLE_CYC)
		else $error("heartbeat flash too long");
	cover property (log_valid);
	cover property (pslverr);
	cover property ($rose(heartbeat_led));
	cover property (led_red_right);
endmodule
bind flaa_core flaa_core_chk #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (
	.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .batt_pct(batt_pct), .backlight(backlight),
	.batt_red_bg(batt_red_bg), .led_red_left(led_red_left), .led_red_right(led_red_right),
	.tone_sel(tone_sel), .log_valid(log_valid), .heartbeat_led(heartbeat_led)
);
`default_nettype wire

// File: test/flaa_core_bench.sv
// Purpose: Self-checking bench for flaa_core
// Assumes: SAMPLE_CYC of 8, so one second is 256 clocks
// Notes:   Levels follow the flaa_cal_mem coefficients: 3.5 times det
`include "flaa_map.vh"
`timescale 1ns/10ps
`default_nettype none
`define CMP(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module flaa_core_bench;
	localparam int SEC = 256;
	logic        ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000, det = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, r;
	logic [2:0]  key_n = 3'h7;
	logic [6:0]  batt_pct = 7'h50;
	logic [7:0]  tmask;
	logic        err, tor, vor, hb_d = 1'b0;
	wire  [31:0] prdata;
	wire  [15:0] cal_rdata, log_level;
	wire  [1:0]  cal_addr;
	wire  [2:0]  tone_sel;
	wire         pready, pslverr, tone_en, vib_en, led_rl, led_al, led_rr, led_ar;
	wire         backlight, hb, red_bg, log_valid;
	int          error_cnt = 0, cmp_count = 0, cyc = 0, hb_last = -1, hb_gap = 0, gap;
	flaa_core #(.SAMPLE_CYC(8)) dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.det0(det), .det1(det), .det2(det), .cal_addr(cal_addr), .cal_rdata(cal_rdata),
		.key_n(key_n), .batt_pct(batt_pct), .tone_en(tone_en), .tone_sel(tone_sel),
		.vib_en(vib_en), .led_red_left(led_rl), .led_amber_left(led_al),
		.led_red_right(led_rr), .led_amber_right(led_ar), .backlight(backlight),
		.heartbeat_led(hb), .batt_red_bg(red_bg), .log_valid(log_valid), .log_level(log_level)
	);
	flaa_cal_mem u_mem (.cal_addr(cal_addr), .cal_rdata(cal_rdata));
	always #4 ref_clk = ~ref_clk;
	// ====================================================
	// Heartbeat spacing monitor
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		hb_d <= hb;
		if (hb && !hb_d) begin
			if (hb_last >= 0) hb_gap <= cyc - hb_last;
			hb_last <= cyc;
		end
	end
	// ====================================================
	// Tasks
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge ref_clk) penable <= 1'b1;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin error_cnt++; end_of_test; end
		r = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task wait_log;
		int n;
		n = 0;
		do begin @(posedge ref_clk); n++; end while (log_valid !== 1'b1 && n < 3000);
		if (n >= 3000) begin error_cnt++; end_of_test; end
	endtask
	// Three logs so the compared record holds only post-change samples
	task settle(input logic [11:0] d, input logic [1:0] a);
		det <= d;
		wait_log; wait_log; wait_log;
		repeat (4) @(posedge ref_clk);
		apb(1'b0, `FLAA_OFF_STATUS, 32'h0000_0000);
		`CMP(r[1:0], a)
	endtask
	task watch(input int n);
		tor = 1'b0; vor = 1'b0; tmask = 8'h00;
		repeat (n) begin
			repeat (8) @(posedge ref_clk);
			tor |= tone_en; vor |= vib_en; tmask[tone_sel] = 1'b1;
		end
	endtask
	task press;
		key_n <= 3'h6;
		repeat (4) @(posedge ref_clk);
		key_n <= 3'h7;
		repeat (8) @(posedge ref_clk);
	endtask
	// ====================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, `FLAA_OFF_CTRL, 32'h0000_0000); `CMP(r, 32'h0000_0024)
		apb(1'b0, `FLAA_OFF_ALM1, 32'h0000_0000); `CMP(r, 32'h0000_0032)
		apb(1'b0, `FLAA_OFF_ALM2, 32'h0000_0000); `CMP(r, 32'h0000_00C8)
		apb(1'b0, 12'h0FC, 32'h0000_0000); `CMP({err, r}, {1'b1, 32'h0000_0000})
		apb(1'b1, `FLAA_OFF_ALM1, 32'h0000_0003);
		apb(1'b0, `FLAA_OFF_ALM1, 32'h0000_0000); `CMP(r, 32'h0000_0005)
		apb(1'b1, `FLAA_OFF_ALM2, 32'h0000_000A);
		apb(1'b0, `FLAA_OFF_ALM2, 32'h0000_0000); `CMP(r, 32'h0000_0014)
		apb(1'b1, `FLAA_OFF_ALM1, 32'h0000_0032);
		apb(1'b1, `FLAA_OFF_ALM2, 32'h0000_00C8);
		apb(1'b1, `FLAA_OFF_CTRL, 32'h0000_0020);
		apb(1'b0, `FLAA_OFF_STATUS, 32'h0000_0000); `CMP(r[4], 1'b1)
		settle(12'h010, 2'h1);
		`CMP(log_level, 16'h0038)
		`CMP({led_rl, led_al, led_rr, led_ar}, 4'hC)
		`CMP(tone_en ^ vib_en, 1'b1)
		repeat (2 * SEC) @(posedge ref_clk);
		apb(1'b0, `FLAA_OFF_LEVEL, 32'h0000_0000); `CMP(r, 32'h0000_0038)
		for (int i = 1; i < 3; i++) begin
			apb(1'b1, `FLAA_OFF_CTRL, 32'h0000_0020 | i);
			watch(40); `CMP({tor, vor}, {i == 1, i == 2})
		end
		apb(1'b1, `FLAA_OFF_CTRL, 32'h0000_0020);
		settle(12'h040, 2'h2);
		watch(48); `CMP(tmask, 8'h1F)
		`CMP({led_rl ^ led_rr, led_al ^ led_ar}, 2'h3)
		settle(12'h010, 2'h1);
		apb(1'b1, `FLAA_OFF_ALM1, 32'h0000_0000);
		settle(12'h010, 2'h0);
		settle(12'h040, 2'h2);
		apb(1'b1, `FLAA_OFF_ALM1, 32'h0000_0032);
		settle(12'h000, 2'h0);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `FLAA_OFF_CTRL, 32'h0000_0020 | (i << 2));
			wait_log; gap = cyc; wait_log;
			`CMP(cyc - gap, i == 0 ? 64 : (i == 1 ? SEC : 5 * SEC))
		end
		apb(1'b1, `FLAA_OFF_CTRL, 32'h0000_0020);
		batt_pct <= 7'h0F;
		repeat (8) @(posedge ref_clk);
		`CMP(red_bg, 1'b1)
		batt_pct <= 7'h05;
		press; watch(40); `CMP({tor, vor, backlight}, 3'h4)
		batt_pct <= 7'h50;
		repeat (8) @(posedge ref_clk);
		`CMP(red_bg, 1'b0)
		press; `CMP(backlight, 1'b1)
		repeat (8 * SEC + 128) @(posedge ref_clk);
		press;
		repeat (8 * SEC + 128) @(posedge ref_clk);
		`CMP(backlight, 1'b1)
		repeat (2 * SEC) @(posedge ref_clk);
		`CMP(backlight, 1'b0)
		`CMP(hb_gap, 10 * SEC)
		end_of_test;
	end
endmodule
`default_nettype wire
